// ===== bench/tb_top.sv
// Self-checking testbench for the serial control, status and baud block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [2:0] io_addr_i = 3'h0;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic global_irq_enable_i = 1'b0;
  logic tx_done_irq_ack_i = 1'b0;
  logic xck_i = 1'b0;
  logic [7:0] io_rdata_o;
  logic rxd, txd_o, txd_override_o, rxd_override_o;
  logic rx_done_irq_o, tx_done_irq_o, data_empty_irq_o;
  logic [7:0] d;
  logic [8:0] b1, b2;
  int fail_count = 0;
  int n_tests = 0;
  wire logic [7:0] irqs = {5'h00, rx_done_irq_o, tx_done_irq_o, data_empty_irq_o};
  ucsb_regs ucsb_regs_i (
    .clock_i(clock_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .global_irq_enable_i(global_irq_enable_i), .tx_done_irq_ack_i(tx_done_irq_ack_i),
    .rxd_i(rxd), .xck_i(xck_i), .txd_o(txd_o), .txd_override_o(txd_override_o),
    .rxd_override_o(rxd_override_o), .rx_done_irq_o(rx_done_irq_o),
    .tx_done_irq_o(tx_done_irq_o), .data_empty_irq_o(data_empty_irq_o));
  ucsb_remote ucsb_remote_i (.clock_i(clock_i), .txd_i(txd_o), .rxd_o(rxd));
  initial forever #4 clock_i = ~clock_i;
  task automatic chk(input logic [7:0] got, input logic [7:0] e, input string m);
    n_tests++;
    if (got !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock_i);
    io_wr_i <= 1'b1;
    io_addr_i <= a;
    io_wdata_i <= v;
    @(posedge clock_i);
    io_wr_i <= 1'b0;
    @(negedge clock_i);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v, input int n = 1);
    @(posedge clock_i);
    io_rd_i <= 1'b1;
    io_addr_i <= a;
    repeat (n) @(posedge clock_i);
    io_rd_i <= 1'b0;
    @(negedge clock_i);
    v = io_rdata_o;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e, input string m, input int n = 1);
    rd(a, d, n);
    chk(d, e, m);
  endtask
  task automatic t_reset();
    rc(3'h1, 8'h20, "ctrl A reset");
    rc(3'h2, 8'h00, "ctrl B reset");
    rc(3'h3, 8'h00, "shared single read");
    rc(3'h3, 8'h83, "shared double read", 2);
    rc(3'h5, 8'h00, "unmapped read");
  endtask
  task automatic t_setup();
    wr(3'h3, 8'h0f);
    rc(3'h3, 8'h0f, "baud high");
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h86);
    rc(3'h3, 8'h86, "frame ctrl", 2);
    wr(3'h2, 8'h18);
    chk({6'h00, txd_override_o, rxd_override_o}, 8'h03, "pin takeover");
  endtask
  task automatic t_tx();
    fork
      begin
        ucsb_remote_i.get(b1);
        ucsb_remote_i.get(b2);
      end
      begin
        wr(3'h0, 8'h3c);
        d = 8'h00;
        for (int i = 0; i < 40 && !d[5]; i++) rd(3'h1, d);
        wr(3'h0, 8'hc3);
        wr(3'h0, 8'h99);
        wr(3'h2, 8'h10);
        chk({7'h00, txd_override_o}, 8'h01, "tx pin held while draining");
      end
    join
    chk(b1[7:0], 8'h3c, "first frame");
    chk(b2[7:0], 8'hc3, "second frame");
    repeat (64) @(posedge clock_i);
    chk({7'h00, txd_override_o}, 8'h00, "tx pin released");
    rc(3'h1, 8'h60, "tx complete");
    wr(3'h2, 8'h18);
  endtask
  task automatic t_irq();
    wr(3'h2, 8'hf8);
    chk(irqs, 8'h00, "irq without global");
    global_irq_enable_i <= 1'b1;
    rc(3'h1, 8'h60, "ctrl A with irqs");
    chk(irqs, 8'h03, "irq with global");
    wr(3'h1, 8'h40);
    chk(irqs, 8'h01, "tx irq cleared");
    global_irq_enable_i <= 1'b0;
    wr(3'h2, 8'h18);
  endtask
  task automatic t_dbl();
    wr(3'h1, 8'h02);
    ucsb_remote_i.bit_clks = 8;
    fork
      ucsb_remote_i.get(b1);
      wr(3'h0, 8'ha5);
    join
    chk(b1[7:0], 8'ha5, "double speed frame");
    repeat (32) @(posedge clock_i);
    tx_done_irq_ack_i <= 1'b1;
    @(posedge clock_i);
    tx_done_irq_ack_i <= 1'b0;
    rc(3'h1, 8'h22, "tx complete acked");
    wr(3'h1, 8'h40);
    ucsb_remote_i.bit_clks = 16;
  endtask
  task automatic t_rx();
    wr(3'h2, 8'h98);
    for (int i = 1; i < 5; i++) ucsb_remote_i.send({1'b1, 8'h11 * i[7:0], 1'b0}, 10);
    chk(irqs, 8'h00, "rx irq without global");
    global_irq_enable_i <= 1'b1;
    rc(3'h1, 8'ha8, "overrun set");
    chk(irqs, 8'h04, "rx irq with global");
    global_irq_enable_i <= 1'b0;
    rc(3'h0, 8'h11, "first char");
    rc(3'h1, 8'ha0, "overrun after read");
    rc(3'h0, 8'h22, "second char");
    rc(3'h0, 8'h33, "held char");
    rc(3'h1, 8'h20, "queue empty");
    wr(3'h2, 8'h18);
  endtask
  task automatic t_par();
    for (int m = 0; m < 4; m++)
    begin
      wr(3'h3, {2'h2, m[1:0], 4'h6});
      ucsb_remote_i.send({2'h3, 8'h0f, 1'b0}, 11);
      rc(3'h1, 8'ha0 | (m == 2 ? 8'h04 : 8'h00), "parity flag");
      rc(3'h0, 8'h0f, "parity char");
    end
    wr(3'h3, 8'h86);
    ucsb_remote_i.send({2'h0, 8'h0f, 1'b0}, 10);
    rc(3'h1, 8'hb0, "frame error flag");
    rc(3'h0, 8'h0f, "frame error char");
  endtask
  task automatic t_sync();
    for (int p = 0; p < 2; p++)
    begin
      xck_i <= p[0];
      wr(3'h3, {7'h63, p[0]});
      wr(3'h0, 8'h96);
      for (int i = 0; i < 11; i++)
      begin
        repeat (4) @(posedge clock_i);
        xck_i <= !p[0];
        repeat (4) @(posedge clock_i);
        xck_i <= p[0];
        if (i > 0 && i < 9) d[i-1] = txd_o;
      end
      chk(d, 8'h96, "sync frame");
      repeat (8) @(posedge clock_i);
      wr(3'h1, 8'h40);
    end
    wr(3'h3, 8'h86);
  endtask
  task automatic t_misc();
    wr(3'h2, 8'h1c);
    ucsb_remote_i.send({2'h3, 8'h5a, 1'b0}, 11);
    rc(3'h2, 8'h1e, "ninth bit");
    rc(3'h0, 8'h5a, "low bits");
    wr(3'h2, 8'h1d);
    fork
      ucsb_remote_i.get(b1);
      wr(3'h0, 8'ha5);
    join
    chk(b1[7:0], 8'ha5, "nine bit low");
    chk({7'h00, b1[8]}, 8'h01, "nine bit high");
    repeat (32) @(posedge clock_i);
    wr(3'h1, 8'h40);
    wr(3'h2, 8'h18);
    wr(3'h1, 8'h01);
    ucsb_remote_i.send({2'h0, 8'h55, 1'b0}, 10);
    ucsb_remote_i.send({2'h1, 8'h66, 1'b0}, 10);
    rc(3'h1, 8'ha1, "address frame only");
    rc(3'h0, 8'h66, "address char");
    wr(3'h1, 8'h00);
    ucsb_remote_i.send({2'h1, 8'h77, 1'b0}, 10);
    wr(3'h2, 8'h08);
    chk({7'h00, rxd_override_o}, 8'h00, "rx pin released");
    rc(3'h1, 8'h20, "queue flushed");
    wr(3'h2, 8'h18);
    rc(3'h1, 8'h20, "empty after enable");
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_reset();
    t_setup();
    t_tx();
    t_irq();
    t_dbl();
    t_rx();
    t_par();
    t_sync();
    t_misc();
    test_done();
  end
  initial
  begin
    repeat (30000) @(posedge clock_i);
    fail_count++;
    test_done();
  end
endmodule
bind ucsb_regs ucsb_regs_chk ucsb_regs_chk_i (
  .clock_i(clock_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
  .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
  .global_irq_enable_i(global_irq_enable_i), .tx_done_irq_ack_i(tx_done_irq_ack_i),
  .rxd_i(rxd_i), .xck_i(xck_i), .txd_o(txd_o), .txd_override_o(txd_override_o),
  .rxd_override_o(rxd_override_o), .rx_done_irq_o(rx_done_irq_o),
  .tx_done_irq_o(tx_done_irq_o), .data_empty_irq_o(data_empty_irq_o));
`default_nettype wire

// ===== bench/ucsb_regs_chk.sv
// Port checker for the serial control, status and baud block
`timescale 1ns/1ps
`default_nettype none
module ucsb_regs_chk (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [2:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic global_irq_enable_i,
  input wire logic tx_done_irq_ack_i,
  input wire logic rxd_i,
  input wire logic xck_i,
  input wire logic txd_o,
  input wire logic txd_override_o,
  input wire logic rxd_override_o,
  input wire logic rx_done_irq_o,
  input wire logic tx_done_irq_o,
  input wire logic data_empty_irq_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  logic rd_sh;
  logic rd_a;
  logic b_wr;
  assign rd_sh = io_rd_i && io_addr_i == 3'h3;
  assign rd_a = io_rd_i && io_addr_i == 3'h1;
  assign b_wr = io_wr_i && io_addr_i == 3'h2;
  shared_hi_a: assert property (rd_sh && !$past(rd_sh) |=> io_rdata_o[7:4] == 4'h0)
    else $error("single shared read did not give baud high");
  shared_c_a: assert property (rd_sh ##1 rd_sh |=> io_rdata_o[7])
    else $error("back to back shared read did not give frame control");
  rx_on_a: assert property (b_wr && io_wdata_i[4] |=> rxd_override_o)
    else $error("receiver enable did not take the pin");
  rx_off_a: assert property (b_wr && !io_wdata_i[4] |=> !rxd_override_o)
    else $error("receiver disable kept the pin");
  rx_flush_a: assert property (rd_a && !rxd_override_o |=> (io_rdata_o & 8'h9c) == 8'h00)
    else $error("receive flags seen with receiver off");
  tx_on_a: assert property (b_wr && io_wdata_i[3] |=> txd_override_o)
    else $error("transmitter enable did not take the pin");
  tx_release_a: assert property ($fell(txd_override_o) |-> txd_o && $past(txd_o))
    else $error("tx pin released in mid frame");
  irq_gate_a: assert property (!global_irq_enable_i |->
    !(rx_done_irq_o || tx_done_irq_o || data_empty_irq_o))
    else $error("interrupt without global flag");
  irq_rx_a: assert property (rx_done_irq_o && rd_a |=> io_rdata_o[7])
    else $error("rx interrupt without its flag");
  irq_tx_a: assert property (tx_done_irq_o && rd_a |=> io_rdata_o[6])
    else $error("tx interrupt without its flag");
  irq_empty_a: assert property (data_empty_irq_o && rd_a |=> io_rdata_o[5])
    else $error("empty interrupt without its flag");
endmodule
`default_nettype wire

// ===== bench/ucsb_remote.sv
// Behavioural remote serial transceiver on the async serial pins
`timescale 1ns/1ps
`default_nettype none
module ucsb_remote (
  input wire logic clock_i,
  input wire logic txd_i,
  output var logic rxd_o
);
  int bit_clks = 16;
  initial rxd_o = 1'b1;
  // Bits go out LSB first, start bit included, then two idle bits
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clock_i);
      rxd_o <= f[i];
      repeat (bit_clks - 1) @(posedge clock_i);
    end
    @(posedge clock_i);
    rxd_o <= 1'b1;
    repeat (bit_clks * 2) @(posedge clock_i);
  endtask
  // Samples nine bit slots after the start bit, in mid bit
  task automatic get(output logic [8:0] b);
    @(negedge txd_i);
    repeat (bit_clks / 2) @(posedge clock_i);
    for (int i = 0; i < 9; i++)
    begin
      repeat (bit_clks) @(posedge clock_i);
      b[i] = txd_i;
    end
  endtask
endmodule
`default_nettype wire

// ===== hdl/ucsb_baud.v
// Baud prescaler: one tick every divisor+1 clocks
`timescale 1ns/1ps
`default_nettype none
module ucsb_baud #(
  parameter W = 12
) (
  input wire clock_i,
  input wire nrst_i,
  input wire [W-1:0] divisor_i,
  input wire reload_i,
  output reg tick_o
);
  reg [W-1:0] count;
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      count <= {W{1'b0}};
      tick_o <= 1'b0;
    end
    else if (reload_i)
    begin
      count <= divisor_i;
      tick_o <= 1'b0;
    end
    else if (count == {W{1'b0}})
    begin
      count <= divisor_i;
      tick_o <= 1'b1;
    end
    else
    begin
      count <= count - 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/ucsb_consts.vh
// Constants for the serial port control, status and baud block
`ifndef UCSB_CONSTS_VH
`define UCSB_CONSTS_VH
`define UCSB_LOC_DATA 3'h0
`define UCSB_LOC_A 3'h1
`define UCSB_LOC_B 3'h2
`define UCSB_LOC_SHARED 3'h3
`define UCSB_LOC_BAUD_LO 3'h4
`define UCSB_RXDONE 7
`define UCSB_TXDONE 6
`define UCSB_TXEMPTY 5
`define UCSB_FRAME_ERR 4
`define UCSB_OVERRUN 3
`define UCSB_PAR_ERR 2
`define UCSB_DBL 1
`define UCSB_MPROC 0
`define UCSB_RXDONE_IE 7
`define UCSB_TXDONE_IE 6
`define UCSB_EMPTY_IE 5
`define UCSB_RX_EN 4
`define UCSB_TX_EN 3
`define UCSB_SIZE_HI 2
`define UCSB_RX_BIT8 1
`define UCSB_TX_BIT8 0
`define UCSB_SEL 7
`define UCSB_SYNC 6
`define UCSB_PAR_HI 5
`define UCSB_PAR_LO 4
`define UCSB_STOP2 3
`define UCSB_SIZE_LO1 2
`define UCSB_SIZE_LO0 1
`define UCSB_POL 0
`define UCSB_BAUD_HI_MSB 3
`define UCSB_C_RESET 7'h03
`define UCSB_OS_NORMAL 5'h10
`define UCSB_OS_DOUBLE 5'h08
`define UCSB_SIZE_9 3'h7
`define UCSB_QW 11
`endif

// ===== hdl/ucsb_fifo.v
// Small FIFO holding received characters with their error bits
`timescale 1ns/1ps
`default_nettype none
module ucsb_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock_i,
  input wire nrst_i,
  input wire flush_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  localparam [31:0] DEPTH_M1 = DEPTH - 1;
  localparam [31:0] DEPTH_W = DEPTH;
  localparam [AW-1:0] LAST = DEPTH_M1[AW-1:0];
  localparam [AW:0] FULL = DEPTH_W[AW:0];
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = count != FULL;
  assign out_valid_o = count != {(AW+1){1'b0}};
  assign out_data_o = mem[rd_ptr];
  always @(posedge clock_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else if (flush_i)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == LAST) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == LAST) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/ucsb_regs.v
// Serial port control, status and baud registers with frame engines
// How it works
// - overrun when queue full, hold full, new start
// - error flags kept until data read; writes ignored
// - parity error only if checked at arrival
// - double speed divides by 8, async only
// - multiprocessor mode drops frames without address
// - interrupt needs enable, global flag, status flag
// - receiver takes pin; disable flushes queue, flags
// - transmitter keeps pin until fully drained
// - select bit picks frame control or baud high
// - mode bit zero async, one sync
// - parity field off, reserved, even, odd
// - parity appended on send, checked on receive
// - stop select affects transmitter only
// - size code gives 5 to 9 bits
// - polarity picks change and sample clock edges
// - divisor is twelve bits over two registers
// - writing baud low reloads the prescaler
// - back-to-back read of shared location gives frame control
// - data writes dropped when full; reads pop queue
`include "ucsb_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module ucsb_regs #(
  parameter RXQ_DEPTH = 2,
  parameter RXQ_AW = 1,
  parameter DIV_W = 12
) (
  input wire clock_i,
  input wire nrst_i,
  input wire [2:0] io_addr_i,
  input wire io_wr_i,
  input wire io_rd_i,
  input wire [7:0] io_wdata_i,
  output reg [7:0] io_rdata_o,
  input wire global_irq_enable_i,
  input wire tx_done_irq_ack_i,
  input wire rxd_i,
  input wire xck_i,
  output reg txd_o,
  output wire txd_override_o,
  output wire rxd_override_o,
  output wire rx_done_irq_o,
  output wire tx_done_irq_o,
  output wire data_empty_irq_o
);
  localparam [2:0] T_IDLE = 3'h0;
  localparam [2:0] T_START = 3'h1;
  localparam [2:0] T_DATA = 3'h2;
  localparam [2:0] T_PAR = 3'h3;
  localparam [2:0] T_STOP1 = 3'h4;
  localparam [2:0] T_STOP2 = 3'h5;
  localparam [2:0] R_IDLE = 3'h0;
  localparam [2:0] R_START = 3'h1;
  localparam [2:0] R_DATA = 3'h2;
  localparam [2:0] R_PAR = 3'h3;
  localparam [2:0] R_STOP = 3'h4;

  function [3:0] size_bits;
    input [2:0] code;
    begin
      case (code)
        3'h0: size_bits = 4'h5;
        3'h1: size_bits = 4'h6;
        3'h2: size_bits = 4'h7;
        `UCSB_SIZE_9: size_bits = 4'h9;
        default: size_bits = 4'h8;
      endcase
    end
  endfunction

  reg double_speed;
  reg multiproc_mode;
  reg rx_done_irq_enable;
  reg tx_done_irq_enable;
  reg data_empty_irq_enable;
  reg receiver_enable;
  reg transmitter_enable;
  reg char_size_high;
  reg tx_ninth_bit;
  reg sync_mode_select;
  reg [1:0] parity_mode;
  reg stop_bits_select;
  reg [1:0] char_size_low;
  reg clock_polarity;
  reg [3:0] baud_hi;
  reg [7:0] baud_lo;
  reg tx_complete_flag;
  reg overrun_flag;
  reg shared_rd_prev;
  reg rxd_s1;
  reg rxd_s2;
  reg xck_s1;
  reg xck_s2;
  reg xck_s3;
  reg [2:0] tx_st;
  reg [4:0] tx_os;
  reg [3:0] tx_cnt;
  reg [8:0] tx_sh;
  reg tx_par;
  reg [8:0] txbuf;
  reg txbuf_valid;
  reg [2:0] rx_st;
  reg [4:0] rx_os;
  reg [3:0] rx_cnt;
  reg [8:0] rx_data;
  reg rx_par;
  reg rx_perr;
  reg [10:0] hold;
  reg hold_valid;
  reg [7:0] next_rdata;

  wire sel_data = io_addr_i == `UCSB_LOC_DATA;
  wire sel_a = io_addr_i == `UCSB_LOC_A;
  wire sel_b = io_addr_i == `UCSB_LOC_B;
  wire sel_shared = io_addr_i == `UCSB_LOC_SHARED;
  wire sel_lo = io_addr_i == `UCSB_LOC_BAUD_LO;
  wire wr_data = io_wr_i && sel_data;
  wire wr_lo = io_wr_i && sel_lo;
  wire rd_data = io_rd_i && sel_data;
  wire rd_shared = io_rd_i && sel_shared;

  wire [DIV_W-1:0] baud_divisor = {baud_hi, baud_lo};
  wire tick;
  wire [3:0] nbits = size_bits({char_size_high, char_size_low});
  wire [4:0] os_len = (double_speed && !sync_mode_select) ?
    `UCSB_OS_DOUBLE : `UCSB_OS_NORMAL;
  wire [4:0] os_last = os_len - 5'h01;
  wire [4:0] os_half = (os_len >> 1) - 5'h01;
  wire xck_rise = xck_s2 && !xck_s3;
  wire xck_fall = !xck_s2 && xck_s3;
  wire tx_edge = clock_polarity ? xck_fall : xck_rise;
  wire rx_edge = clock_polarity ? xck_rise : xck_fall;
  wire tx_step = sync_mode_select ? tx_edge :
    (tick && tx_os == os_last);
  wire rx_tgt_hit = rx_os == ((rx_st == R_START) ? os_half : os_last);
  wire rx_sample = sync_mode_select ? rx_edge : (tick && rx_tgt_hit);
  wire tx_on = transmitter_enable || tx_st != T_IDLE || txbuf_valid;
  wire tx_tx_buffer_empty_flag = !txbuf_valid;
  wire tx_done = tx_step &&
    ((tx_st == T_STOP1 && !stop_bits_select) || tx_st == T_STOP2);
  wire txc_set = tx_done && !txbuf_valid;
  wire txc_clr = (io_wr_i && sel_a && io_wdata_i[`UCSB_TXDONE]) ||
    tx_done_irq_ack_i;
  wire rx_start_async = !sync_mode_select && rx_st == R_IDLE && !rxd_s2;
  wire rx_start_sync = sync_mode_select && rx_st == R_IDLE && !rxd_s2 &&
    rx_edge;
  wire rx_start = receiver_enable && (rx_start_async || rx_start_sync);
  wire addr_mark = (nbits == 4'h9) ? rx_data[8] : rxd_s2;
  wire rx_keep = !multiproc_mode || addr_mark;
  wire q_in_ready;
  wire q_valid;
  wire [10:0] q_head;
  wire head_fe = q_valid && q_head[9];
  wire head_pe = q_valid && q_head[10];
  wire head_b8 = q_valid && q_head[8];

  ucsb_baud #(
    .W(DIV_W)
  ) u_baud (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .divisor_i(baud_divisor),
    .reload_i(wr_lo),
    .tick_o(tick)
  );

  ucsb_fifo #(
    .WIDTH(`UCSB_QW),
    .DEPTH(RXQ_DEPTH),
    .AW(RXQ_AW)
  ) u_rxq (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .flush_i(!receiver_enable),
    .in_valid_i(hold_valid),
    .in_ready_o(q_in_ready),
    .in_data_i(hold),
    .out_valid_o(q_valid),
    .out_ready_i(rd_data),
    .out_data_o(q_head)
  );

  assign rxd_override_o = receiver_enable;
  assign txd_override_o = tx_on;
  assign rx_done_irq_o = rx_done_irq_enable && global_irq_enable_i && q_valid;
  assign tx_done_irq_o = tx_done_irq_enable && global_irq_enable_i &&
    tx_complete_flag;
  assign data_empty_irq_o = data_empty_irq_enable && global_irq_enable_i &&
    tx_tx_buffer_empty_flag;

  // Pin synchronisers and clock edge history
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      xck_s1 <= 1'b0;
      xck_s2 <= 1'b0;
      xck_s3 <= 1'b0;
    end
    else
    begin
      rxd_s1 <= rxd_i;
      rxd_s2 <= rxd_s1;
      xck_s1 <= xck_i;
      xck_s2 <= xck_s1;
      xck_s3 <= xck_s2;
    end
  end

  // Register writes
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      double_speed <= 1'b0;
      multiproc_mode <= 1'b0;
      rx_done_irq_enable <= 1'b0;
      tx_done_irq_enable <= 1'b0;
      data_empty_irq_enable <= 1'b0;
      receiver_enable <= 1'b0;
      transmitter_enable <= 1'b0;
      char_size_high <= 1'b0;
      tx_ninth_bit <= 1'b0;
      {sync_mode_select, parity_mode, stop_bits_select, char_size_low,
        clock_polarity} <= `UCSB_C_RESET;
      baud_hi <= 4'h0;
      baud_lo <= 8'h00;
    end
    else if (io_wr_i)
    begin
      if (sel_a)
      begin
        // Error and status flag positions are not stored; a one at the TXDONE position clears tx_complete_flag
        double_speed <= io_wdata_i[`UCSB_DBL];
        multiproc_mode <= io_wdata_i[`UCSB_MPROC];
      end
      if (sel_b)
      begin
        rx_done_irq_enable <= io_wdata_i[`UCSB_RXDONE_IE];
        tx_done_irq_enable <= io_wdata_i[`UCSB_TXDONE_IE];
        data_empty_irq_enable <= io_wdata_i[`UCSB_EMPTY_IE];
        receiver_enable <= io_wdata_i[`UCSB_RX_EN];
        transmitter_enable <= io_wdata_i[`UCSB_TX_EN];
        char_size_high <= io_wdata_i[`UCSB_SIZE_HI];
        tx_ninth_bit <= io_wdata_i[`UCSB_TX_BIT8];
      end
      if (sel_shared && io_wdata_i[`UCSB_SEL])
      begin
        sync_mode_select <= io_wdata_i[`UCSB_SYNC];
        parity_mode <= io_wdata_i[`UCSB_PAR_HI:`UCSB_PAR_LO];
        stop_bits_select <= io_wdata_i[`UCSB_STOP2];
        char_size_low <= io_wdata_i[`UCSB_SIZE_LO1:`UCSB_SIZE_LO0];
        clock_polarity <= io_wdata_i[`UCSB_POL];
      end
      if (sel_shared && !io_wdata_i[`UCSB_SEL])
        baud_hi <= io_wdata_i[`UCSB_BAUD_HI_MSB:0];
      if (sel_lo)
        baud_lo <= io_wdata_i;
    end
  end

  // Status flags; a set in the same cycle beats a clear
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tx_complete_flag <= 1'b0;
      overrun_flag <= 1'b0;
      shared_rd_prev <= 1'b0;
    end
    else
    begin
      shared_rd_prev <= rd_shared;
      if (txc_set)
        tx_complete_flag <= 1'b1;
      else if (txc_clr)
        tx_complete_flag <= 1'b0;
      if (!receiver_enable)
        overrun_flag <= 1'b0;
      else if (rx_start && hold_valid && !q_in_ready)
        overrun_flag <= 1'b1;
      else if (rd_data)
        overrun_flag <= 1'b0;
    end
  end

  // Transmit buffer and frame sender
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      txbuf <= 9'h000;
      txbuf_valid <= 1'b0;
      tx_st <= T_IDLE;
      tx_os <= 5'h00;
      tx_cnt <= 4'h0;
      tx_sh <= 9'h000;
      tx_par <= 1'b0;
      txd_o <= 1'b1;
    end
    else
    begin
      if (tick)
        tx_os <= (tx_os == os_last) ? 5'h00 : tx_os + 5'h01;
      if (wr_data && tx_tx_buffer_empty_flag)
      begin
        txbuf <= {tx_ninth_bit, io_wdata_i};
        txbuf_valid <= 1'b1;
      end
      if (tx_step)
      begin
        case (tx_st)
          T_IDLE:
          begin
            if (txbuf_valid && tx_on)
            begin
              txd_o <= 1'b0;
              tx_sh <= txbuf;
              txbuf_valid <= 1'b0;
              tx_par <= parity_mode[0];
              tx_cnt <= 4'h0;
              tx_st <= T_START;
            end
          end
          T_START, T_DATA:
          begin
            if (tx_cnt == nbits)
            begin
              if (parity_mode[1])
              begin
                txd_o <= tx_par;
                tx_st <= T_PAR;
              end
              else
              begin
                txd_o <= 1'b1;
                tx_st <= T_STOP1;
              end
            end
            else
            begin
              txd_o <= tx_sh[tx_cnt];
              tx_par <= tx_par ^ tx_sh[tx_cnt];
              tx_cnt <= tx_cnt + 4'h1;
              tx_st <= T_DATA;
            end
          end
          T_PAR:
          begin
            txd_o <= 1'b1;
            tx_st <= T_STOP1;
          end
          T_STOP1:
          begin
            txd_o <= 1'b1;
            tx_st <= stop_bits_select ? T_STOP2 : T_IDLE;
          end
          default:
          begin
            txd_o <= 1'b1;
            tx_st <= T_IDLE;
          end
        endcase
      end
    end
  end

  // Frame receiver and holding stage ahead of the queue
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_st <= R_IDLE;
      rx_os <= 5'h00;
      rx_cnt <= 4'h0;
      rx_data <= 9'h000;
      rx_par <= 1'b0;
      rx_perr <= 1'b0;
      hold <= 11'h000;
      hold_valid <= 1'b0;
    end
    else if (!receiver_enable)
    begin
      rx_st <= R_IDLE;
      hold_valid <= 1'b0;
    end
    else
    begin
      if (hold_valid && q_in_ready)
        hold_valid <= 1'b0;
      if (rx_st == R_IDLE || rx_sample)
        rx_os <= 5'h00;
      else if (tick)
        rx_os <= rx_os + 5'h01;
      if (rx_start)
      begin
        rx_data <= 9'h000;
        rx_cnt <= 4'h0;
        rx_par <= 1'b0;
        rx_perr <= 1'b0;
        rx_st <= sync_mode_select ? R_DATA : R_START;
      end
      else if (rx_sample)
      begin
        case (rx_st)
          R_START:
            rx_st <= rxd_s2 ? R_IDLE : R_DATA;
          R_DATA:
          begin
            rx_data[rx_cnt] <= rxd_s2;
            rx_par <= rx_par ^ rxd_s2;
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == nbits - 4'h1)
              rx_st <= parity_mode[1] ? R_PAR : R_STOP;
          end
          R_PAR:
          begin
            rx_perr <= rx_par ^ rxd_s2 ^ parity_mode[0];
            rx_st <= R_STOP;
          end
          R_STOP:
          begin
            // Only the first stop bit is checked
            if (rx_keep && !hold_valid)
            begin
              hold <= {rx_perr, !rxd_s2, rx_data};
              hold_valid <= 1'b1;
            end
            rx_st <= R_IDLE;
          end
          default:
            rx_st <= R_IDLE;
        endcase
      end
    end
  end

  // Read data mux
  always @*
  begin
    next_rdata = 8'h00;
    case (io_addr_i)
      `UCSB_LOC_DATA:
        next_rdata = q_head[7:0];
      `UCSB_LOC_A:
      begin
        next_rdata[`UCSB_RXDONE] = q_valid;
        next_rdata[`UCSB_TXDONE] = tx_complete_flag;
        next_rdata[`UCSB_TXEMPTY] = tx_tx_buffer_empty_flag;
        next_rdata[`UCSB_FRAME_ERR] = head_fe;
        next_rdata[`UCSB_OVERRUN] = overrun_flag;
        next_rdata[`UCSB_PAR_ERR] = head_pe;
        next_rdata[`UCSB_DBL] = double_speed;
        next_rdata[`UCSB_MPROC] = multiproc_mode;
      end
      `UCSB_LOC_B:
        next_rdata = {rx_done_irq_enable, tx_done_irq_enable,
          data_empty_irq_enable, receiver_enable, transmitter_enable,
          char_size_high, head_b8, tx_ninth_bit};
      `UCSB_LOC_SHARED:
        if (shared_rd_prev)
          next_rdata = {1'b1, sync_mode_select, parity_mode,
            stop_bits_select, char_size_low, clock_polarity};
        else
          next_rdata = {4'h0, baud_hi};
      `UCSB_LOC_BAUD_LO:
        next_rdata = baud_lo;
      default:
        next_rdata = 8'h00;
    endcase
  end

  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      io_rdata_o <= 8'h00;
    else if (io_rd_i)
      io_rdata_o <= next_rdata;
  end
endmodule
`default_nettype wire
